/* File: radio_spi_device.sv */
// Command port slave: decodes opcodes and holds radio and converter setup
`timescale 1ns/100ps
`include "radio_spi_cfg.svh"
module radio_spi_device (
  input wire logic clk,
  input wire logic rstn,
  radio_spi_if.device link,
  input wire logic data_ready_flag,
  input wire logic address_match_flag,
  input wire logic conv_end_flag,
  input wire logic conv_range_flag,
  input wire logic adc_busy,
  input wire logic [`TX_PAY_BYTES-1:0][7:0] rx_payload,
  input wire logic [`ADC_DATA_BYTES-1:0][7:0] adc_result,
  output logic [`RADIO_CFG_BYTES-1:0][7:0] radio_setup,
  output logic [`TX_PAY_BYTES-1:0][7:0] tx_payload,
  output logic [`TX_ADDR_BYTES-1:0][7:0] tx_address,
  output logic [`ADC_CFG_HELD-1:0][7:0] adc_setup,
  output logic adc_start,
  output logic adc_abort,
  output logic [3:0] input_select
);

  // --------------------------------------------------------------
  // Link side, clocked by the serial clock
  // --------------------------------------------------------------
  logic [2:0] bit_cnt_r;
  logic [6:0] rx_sh_r;
  logic first_r;
  logic [7:0] op_r;
  logic [5:0] idx_r;
  logic [7:0] tx_sh_r;
  logic miso_r;
  logic conv_tgl_r;
  logic [3:0] conv_sel_r;
  logic [7:0] status_r;
  logic [7:0] rx_byte;
  logic [7:0] cur_op;
  logic [5:0] nxt_n;
  logic byte_done;
  logic data_done;
  logic [6:0] wr_pos;

  assign rx_byte = {rx_sh_r, link.mosi};
  assign byte_done = (bit_cnt_r == 3'h7);
  assign data_done = byte_done & ~first_r;
  assign cur_op = first_r ? rx_byte : op_r;
  assign nxt_n = first_r ? 6'h0 : ((idx_r == 6'h3f) ? idx_r : idx_r + 6'h1);
  assign wr_pos = {3'h0, op_r[3:0]} + {1'b0, idx_r};

  function automatic radio_spi_pkg::byte_t rd_byte(input logic [7:0] op, input logic [5:0] n);
    logic [6:0] k;
    k = {3'h0, op[3:0]} + {1'b0, n};
    rd_byte = 8'h00;
    if (op[7:4] == `OP_RD_RADIO) begin
      if (k < 7'(`RADIO_CFG_BYTES)) rd_byte = radio_setup[k[3:0]];
    end else if (op == `OP_RD_TX_PAY) begin
      if (n < 6'(`TX_PAY_BYTES)) rd_byte = tx_payload[n[4:0]];
    end else if (op == `OP_RD_TX_ADDR) begin
      if (n < 6'(`TX_ADDR_BYTES)) rd_byte = tx_address[n[1:0]];
    end else if (op == `OP_RD_RX_PAY) begin
      if (n < 6'(`TX_PAY_BYTES)) rd_byte = rx_payload[n[4:0]];
    end else if (op[7:1] == `OP_RD_ADC_DATA) begin
      k = {1'b0, n} + {6'h0, op[0]};
      if (k < 7'(`ADC_DATA_BYTES)) rd_byte = adc_result[k[0]];
    end else if (op == `OP_RD_ADC_CFG) begin
      // Reserved third byte reads zero
      if (n < 6'(`ADC_CFG_HELD)) rd_byte = adc_setup[n[0]];
    end
  endfunction

  // Frame state clears while select is high, so a cut byte is dropped
  always_ff @(posedge link.sck or posedge link.chip_select_n or negedge rstn) begin
    if (!rstn || link.chip_select_n) begin
      bit_cnt_r <= 3'h0;
      rx_sh_r <= 7'h00;
      first_r <= 1'b1;
      op_r <= 8'h00;
      idx_r <= 6'h00;
      tx_sh_r <= 8'h00;
    end else begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      rx_sh_r <= rx_byte[6:0];
      if (byte_done) begin
        first_r <= 1'b0;
        tx_sh_r <= rd_byte(cur_op, nxt_n);
        if (first_r) begin
          op_r <= rx_byte;
        end else begin
          idx_r <= nxt_n;
        end
      end
    end
  end

  // Changed on the falling edge for mode 0
  always_ff @(negedge link.sck or posedge link.chip_select_n or negedge rstn) begin
    if (!rstn || link.chip_select_n) begin
      miso_r <= 1'b0;
    end else if (first_r) begin
      miso_r <= status_r[3'h7 - bit_cnt_r];
    end else begin
      miso_r <= tx_sh_r[3'h7 - bit_cnt_r];
    end
  end

  // First status bit must stand before any clock edge
  assign link.miso = (first_r && bit_cnt_r == 3'h0) ? status_r[7] : miso_r;
  assign link.miso_oe = ~link.chip_select_n;

  // --------------------------------------------------------------
  // Register writes, complete bytes only
  // --------------------------------------------------------------
  always_ff @(posedge link.sck or negedge rstn) begin
    if (!rstn) begin
      radio_setup <= '0;
    end else if (data_done) begin
      if (op_r[7:4] == `OP_WR_RADIO && wr_pos < 7'(`RADIO_CFG_BYTES)) begin
        radio_setup[wr_pos[3:0]] <= rx_byte;
      end else if (op_r[7:4] == `OP_CHANNEL && idx_r == 6'h0) begin
        radio_setup[0] <= rx_byte;
        radio_setup[`RS_CH_HI_BYTE][`RS_CH_FIELD] <= op_r[3:0];
      end
    end
  end

  always_ff @(posedge link.sck or negedge rstn) begin
    if (!rstn) begin
      tx_payload <= '0;
    end else if (data_done && op_r == `OP_WR_TX_PAY && idx_r < 6'(`TX_PAY_BYTES)) begin
      tx_payload[idx_r[4:0]] <= rx_byte;
    end
  end

  always_ff @(posedge link.sck or negedge rstn) begin
    if (!rstn) begin
      tx_address <= '0;
    end else if (data_done && op_r == `OP_WR_TX_ADDR && idx_r < 6'(`TX_ADDR_BYTES)) begin
      tx_address[idx_r[1:0]] <= rx_byte;
    end
  end

  // Reserved byte two is accepted and dropped
  always_ff @(posedge link.sck or negedge rstn) begin
    if (!rstn) begin
      adc_setup <= '0;
    end else if (data_done && op_r == `OP_WR_ADC_CFG && idx_r < 6'(`ADC_CFG_HELD)) begin
      adc_setup[idx_r[0]] <= rx_byte;
    end
  end

  // Start request held until next start; toggle marks the event
  always_ff @(posedge link.sck or negedge rstn) begin
    if (!rstn) begin
      conv_tgl_r <= 1'b0;
      conv_sel_r <= 4'h0;
    end else if (byte_done && first_r && rx_byte[7:4] == `OP_CONV_START) begin
      conv_tgl_r <= ~conv_tgl_r;
      conv_sel_r <= rx_byte[3:0];
    end
  end

  // --------------------------------------------------------------
  // Converter side, clocked by clk
  // --------------------------------------------------------------
  logic cs_s1_r;
  logic cs_s2_r;
  logic tg_s1_r;
  logic tg_s2_r;
  logic tg_s3_r;
  logic pend_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      tg_s1_r <= 1'b0;
      tg_s2_r <= 1'b0;
      tg_s3_r <= 1'b0;
    end else begin
      cs_s1_r <= link.chip_select_n;
      cs_s2_r <= cs_s1_r;
      tg_s1_r <= conv_tgl_r;
      tg_s2_r <= tg_s1_r;
      tg_s3_r <= tg_s2_r;
    end
  end

  // Frozen while select is low so the link reads a still value
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_r <= 8'h00;
    end else if (cs_s2_r) begin
      status_r <= 8'h00;
      status_r[`ST_DATA_READY] <= data_ready_flag;
      status_r[`ST_ADDR_MATCH] <= address_match_flag;
      status_r[`ST_CONV_END] <= conv_end_flag;
      status_r[`ST_CONV_RANGE] <= conv_range_flag;
    end
  end

  // Start waits for select high; a running conversion is aborted
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend_r <= 1'b0;
      adc_start <= 1'b0;
      adc_abort <= 1'b0;
      input_select <= 4'h0;
    end else begin
      adc_start <= 1'b0;
      adc_abort <= 1'b0;
      if (tg_s2_r != tg_s3_r) begin
        pend_r <= 1'b1;
        input_select <= conv_sel_r;
      end else if (pend_r && cs_s2_r) begin
        pend_r <= 1'b0;
        adc_start <= 1'b1;
        adc_abort <= adc_busy;
      end
    end
  end

endmodule

/* File: radio_spi_cfg.svh */
// Constants for the radio and converter command port
`ifndef RADIO_SPI_CFG_SVH
`define RADIO_SPI_CFG_SVH

// --------------------------------------------------------------
// Sizes
// --------------------------------------------------------------
`define RADIO_CFG_BYTES 10
`define TX_PAY_BYTES 32
`define TX_ADDR_BYTES 4
`define ADC_CFG_BYTES 3
`define ADC_CFG_HELD 2
`define ADC_DATA_BYTES 2

// --------------------------------------------------------------
// Opcodes
// --------------------------------------------------------------
`define OP_WR_RADIO 4'h0
`define OP_RD_RADIO 4'h1
`define OP_WR_TX_PAY 8'h20
`define OP_RD_TX_PAY 8'h21
`define OP_WR_TX_ADDR 8'h22
`define OP_RD_TX_ADDR 8'h23
`define OP_RD_RX_PAY 8'h24
`define OP_RD_ADC_DATA 7'h20
`define OP_WR_ADC_CFG 8'h44
`define OP_RD_ADC_CFG 8'h46
`define OP_CHANNEL 4'h8
`define OP_CONV_START 4'hc

// --------------------------------------------------------------
// Status bits and channel fields in radio setup byte 1
// --------------------------------------------------------------
`define ST_DATA_READY 0
`define ST_ADDR_MATCH 1
`define ST_CONV_END 2
`define ST_CONV_RANGE 3
`define RS_CH_HI_BYTE 1
`define RS_CH_FIELD 3:0

// --------------------------------------------------------------
// Host timing in host clock cycles
// --------------------------------------------------------------
`define HOST_HALF 3'h4
`define HOST_LEAD 4'h8
`define HOST_GAP 4'h8

`endif

/* File: radio_spi_pkg.sv */
// Types shared by both ends of the command port
package radio_spi_pkg;
  typedef logic [7:0] byte_t;
  typedef enum {H_IDLE, H_LEAD, H_XFER, H_TAIL, H_GAP} host_state_e;
endpackage

/* File: radio_spi_if.sv */
// Serial link between host port two and the command port
`timescale 1ns/100ps
interface radio_spi_if;
  logic sck;
  logic chip_select_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic miso_line;
  // Undriven line reads low in this model
  assign miso_line = miso_oe & miso;
  modport host (output sck, output chip_select_n, output mosi, input miso_line);
  modport device (input sck, input chip_select_n, input mosi, output miso, output miso_oe);
endinterface

/* File: radio_spi_host.sv */
// Host port two master: drives one instruction per request
`timescale 1ns/100ps
`include "radio_spi_cfg.svh"
module radio_spi_host (
  input wire logic clk,
  input wire logic rstn,
  radio_spi_if.host link,
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [5:0] nbytes,
  input wire logic [`TX_PAY_BYTES-1:0][7:0] wr_data,
  output logic busy,
  output logic done,
  output logic [7:0] status_byte,
  output logic [`TX_PAY_BYTES-1:0][7:0] rd_data
);

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  radio_spi_pkg::host_state_e st_r;
  logic [3:0] wait_r;
  logic [2:0] div_r;
  logic sck_r;
  logic cs_n_r;
  logic [7:0] tx_sh_r;
  logic [7:0] rx_sh_r;
  logic [2:0] bit_r;
  logic [5:0] byte_r;
  logic [5:0] nb_r;
  logic [7:0] op_r;
  logic mi_s1_r;
  logic mi_s2_r;
  logic tick;
  logic [5:0] nxt_byte;
  radio_spi_pkg::byte_t nxt_data;

  assign tick = (div_r == `HOST_HALF - 3'h1);
  assign nxt_byte = byte_r + 6'h1;
  assign nxt_data = (nxt_byte <= 6'(`TX_PAY_BYTES)) ? wr_data[5'(nxt_byte - 6'h1)] : 8'h00;
  assign link.sck = sck_r;
  assign link.chip_select_n = cs_n_r;
  assign link.mosi = tx_sh_r[7];
  assign busy = (st_r != radio_spi_pkg::H_IDLE);

  // Miso comes from the far clock domain
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mi_s1_r <= 1'b0;
      mi_s2_r <= 1'b0;
    end else begin
      mi_s1_r <= link.miso_line;
      mi_s2_r <= mi_s1_r;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= radio_spi_pkg::H_IDLE;
      wait_r <= 4'h0;
      div_r <= 3'h0;
      sck_r <= 1'b0;
      cs_n_r <= 1'b1;
      tx_sh_r <= 8'h00;
      bit_r <= 3'h0;
      byte_r <= 6'h0;
      nb_r <= 6'h0;
      op_r <= 8'h00;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      div_r <= tick ? 3'h0 : div_r + 3'h1;
      case (st_r)
        radio_spi_pkg::H_IDLE: begin
          if (start) begin
            st_r <= radio_spi_pkg::H_LEAD;
            cs_n_r <= 1'b0;
            tx_sh_r <= opcode;
            op_r <= opcode;
            nb_r <= nbytes;
            bit_r <= 3'h0;
            byte_r <= 6'h0;
            wait_r <= 4'h0;
            div_r <= 3'h0;
          end
        end
        // Gives the slave time to freeze status before the first edge
        radio_spi_pkg::H_LEAD: begin
          wait_r <= wait_r + 4'h1;
          if (wait_r == `HOST_LEAD - 4'h1) begin
            st_r <= radio_spi_pkg::H_XFER;
            div_r <= 3'h0;
          end
        end
        radio_spi_pkg::H_XFER: begin
          if (tick) begin
            sck_r <= ~sck_r;
            if (sck_r) begin
              bit_r <= bit_r + 3'h1;
              if (bit_r == 3'h7) begin
                if (byte_r == nb_r) begin
                  st_r <= radio_spi_pkg::H_TAIL;
                  wait_r <= 4'h0;
                end else begin
                  byte_r <= nxt_byte;
                  tx_sh_r <= nxt_data;
                end
              end else begin
                tx_sh_r <= {tx_sh_r[6:0], 1'b0};
              end
            end
          end
        end
        radio_spi_pkg::H_TAIL: begin
          wait_r <= wait_r + 4'h1;
          if (wait_r == {1'b0, `HOST_HALF} - 4'h1) begin
            cs_n_r <= 1'b1;
            st_r <= radio_spi_pkg::H_GAP;
            wait_r <= 4'h0;
          end
        end
        radio_spi_pkg::H_GAP: begin
          wait_r <= wait_r + 4'h1;
          if (wait_r == `HOST_GAP - 4'h1) begin
            st_r <= radio_spi_pkg::H_IDLE;
            done <= 1'b1;
          end
        end
        default: begin
          st_r <= radio_spi_pkg::H_IDLE;
          cs_n_r <= 1'b1;
          sck_r <= 1'b0;
        end
      endcase
    end
  end

  // Sample on the rising edge; status first, then data bytes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_sh_r <= 8'h00;
      status_byte <= 8'h00;
      rd_data <= '0;
    end else if (st_r == radio_spi_pkg::H_XFER && tick && !sck_r) begin
      rx_sh_r <= {rx_sh_r[6:0], mi_s2_r};
      if (bit_r == 3'h7) begin
        if (byte_r == 6'h0) begin
          status_byte <= {rx_sh_r[6:0], mi_s2_r};
        end else if (byte_r <= 6'(`TX_PAY_BYTES)) begin
          rd_data[5'(byte_r - 6'h1)] <= {rx_sh_r[6:0], mi_s2_r};
        end
      end
    end
  end

endmodule

/* File: radio_adc_spi_command_port_monitor.sv */
// Concurrent checks on the serial link between host and command port
`timescale 1ns/100ps
module radio_adc_spi_command_port_monitor (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sck,
  input wire logic chip_select_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic miso_line
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // ------------------------------------------------------------
  // Bit counter
  // ------------------------------------------------------------
  // Host clock is derived from clk, so rises are seen on clk
  logic [2:0] bit_cnt_r;
  logic sck_d_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_r <= 3'h0;
      sck_d_r <= 1'b0;
    end else begin
      sck_d_r <= sck;
      if (chip_select_n) begin
        bit_cnt_r <= 3'h0;
      end else if (sck && !sck_d_r) begin
        bit_cnt_r <= bit_cnt_r + 3'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // Sequences
  // ------------------------------------------------------------
  sequence s_lead;
    !sck [*8];
  endsequence
  sequence s_gap;
    chip_select_n [*8];
  endsequence
  sequence s_high_half;
    sck [*4] ##1 !sck;
  endsequence

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  chk_oe_select_low: assert property (miso_oe == !chip_select_n)
    else $error("data out enable does not follow select");
  chk_sck_idle_low: assert property (chip_select_n |-> !sck)
    else $error("serial clock not low outside frame");
  chk_mosi_held_high: assert property ((sck && !chip_select_n) |-> $stable(mosi))
    else $error("host data moved while clock high");
  chk_miso_held_high: assert property ((sck && !chip_select_n) |-> $stable(miso))
    else $error("device data moved while clock high");
  chk_sck_high_half: assert property ($rose(sck) |-> s_high_half)
    else $error("serial clock high phase wrong");
  chk_sck_low_half: assert property ($fell(sck) |-> !sck [*4])
    else $error("serial clock low phase too short");
  chk_lead_status: assert property ($fell(chip_select_n) |-> s_lead)
    else $error("clock began before status was ready");
  chk_select_gap: assert property ($rose(chip_select_n) |-> s_gap)
    else $error("select high gap too short");
  chk_whole_bytes: assert property ($rose(chip_select_n) |-> bit_cnt_r == 3'h0)
    else $error("frame ended inside a byte");
  // Status bits 7:4 are spare, so the first bit on the line is low
  chk_status_msb_low: assert property ($fell(chip_select_n) |-> !miso_line)
    else $error("first status bit not low");
endmodule

/* File: radio_adc_spi_command_port_test.sv */
// Self-checking bench joining host and command port over the link
`timescale 1ns/100ps
module radio_adc_spi_command_port_test;
  logic clk, rstn, start, busy, done, adc_busy, adc_start, adc_abort;
  logic [7:0] opcode, status_byte, op;
  logic [5:0] nbytes;
  logic [3:0] flags, input_select, sel, sel_seen;
  logic [31:0][7:0] wr_data, rd_data, rx_payload, tx_payload;
  logic [1:0][7:0] adc_result, adc_setup;
  logic [9:0][7:0] radio_setup;
  logic [3:0][7:0] tx_address;
  logic [255:0] exp_pay, exp_addr, exp_adc, exp_radio;
  logic abort_seen, early;
  logic [3:0] starts [3] = '{4'h0, 4'h5, 4'h9};
  int n_fail, checked, n_start, n0, i, a;

  // ------------------------------------------------------------
  // Design
  // ------------------------------------------------------------
  radio_spi_if radio_spi_if_i ();
  radio_spi_host radio_spi_host_i (.clk(clk), .rstn(rstn), .link(radio_spi_if_i),
    .start(start), .opcode(opcode), .nbytes(nbytes), .wr_data(wr_data), .busy(busy),
    .done(done), .status_byte(status_byte), .rd_data(rd_data));
  radio_spi_device radio_spi_device_i (.clk(clk), .rstn(rstn), .link(radio_spi_if_i),
    .data_ready_flag(flags[0]), .address_match_flag(flags[1]), .conv_end_flag(flags[2]),
    .conv_range_flag(flags[3]), .adc_busy(adc_busy), .rx_payload(rx_payload),
    .adc_result(adc_result), .radio_setup(radio_setup), .tx_payload(tx_payload),
    .tx_address(tx_address), .adc_setup(adc_setup), .adc_start(adc_start),
    .adc_abort(adc_abort), .input_select(input_select));
  radio_adc_spi_command_port_monitor radio_adc_spi_command_port_monitor_i (.clk(clk),
    .rstn(rstn), .sck(radio_spi_if_i.sck), .chip_select_n(radio_spi_if_i.chip_select_n),
    .mosi(radio_spi_if_i.mosi), .miso(radio_spi_if_i.miso),
    .miso_oe(radio_spi_if_i.miso_oe), .miso_line(radio_spi_if_i.miso_line));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Conversion pulses, with what stood beside them
  always @(posedge clk) begin
    if (adc_start === 1'b1) begin
      n_start++;
      abort_seen = adc_abort;
      sel_seen = input_select;
      if (radio_spi_if_i.chip_select_n !== 1'b1) early = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [255:0] merge(input logic [255:0] old, input logic [255:0] nw,
      input int first, input int cnt);
    for (int k = 0; k < cnt; k++) old[(first + k) * 8 +: 8] = nw[k * 8 +: 8];
    return old;
  endfunction

  // Read bytes past the count are not defined, so they are masked
  function automatic logic [255:0] lowb(input logic [255:0] v, input int n);
    return (n >= 32) ? v : v & ((256'h1 << (8 * n)) - 256'h1);
  endfunction

  task automatic cmp(input logic [255:0] got, input logic [255:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic fill;
    for (int k = 0; k < 32; k++) wr_data[k] = 8'($urandom);
  endtask

  task automatic xfer(input logic [7:0] o, input logic [5:0] n);
    int k;
    @(posedge clk);
    #1;
    opcode = o;
    nbytes = n;
    start = 1'b1;
    @(posedge clk);
    #1;
    start = 1'b0;
    cmp(256'(busy), 256'h1);
    for (k = 0; k < 4000 && done !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    if (done !== 1'b1) begin
      n_fail++;
      $display("CHECK FAILED at %0t: done %h expected %h", $time, done, 1'b1);
    end
    cmp(256'(busy), 256'h0);
    // Leave off the edge so the next inputs never race the design
    @(posedge clk);
    #1;
  endtask

  task automatic final_report;
    if (n_fail == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #300000;
    n_fail++;
    final_report;
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    {rstn, start, opcode, nbytes, wr_data, flags, adc_busy, rx_payload, adc_result} = '0;
    {exp_pay, exp_addr, exp_adc, exp_radio} = '0;
    {n_fail, checked, n_start, early} = '0;
    void'($urandom(32'h74ad)); // Fixed seed so every run draws the same random values
    repeat (6) @(posedge clk);
    #1 rstn = 1'b1;
    for (i = 0; i < 3; i++) begin
      flags = (i == 0) ? 4'hf : 4'($urandom);
      repeat (3) @(posedge clk);
      xfer(8'h30, 6'd0);
      cmp(256'(status_byte), 256'({4'h0, flags}));
    end
    fill();
    exp_pay = merge(exp_pay, wr_data, 0, 32);
    xfer(8'h20, 6'd32);
    cmp(256'(tx_payload), exp_pay);
    xfer(8'h21, 6'd32);
    cmp(256'(rd_data), exp_pay);
    fill();
    exp_pay = merge(exp_pay, wr_data, 0, 3);
    xfer(8'h20, 6'd3);
    cmp(256'(tx_payload), exp_pay);
    fill();
    exp_addr = merge(exp_addr, wr_data, 0, 4);
    xfer(8'h22, 6'd6);
    cmp(256'(tx_address), exp_addr);
    xfer(8'h23, 6'd2);
    cmp(lowb(256'(rd_data), 2), lowb(exp_addr, 2));
    for (i = 0; i < 32; i++) rx_payload[i] = 8'($urandom);
    xfer(8'h24, 6'd32);
    cmp(256'(rd_data), 256'(rx_payload));
    adc_result = 16'($urandom);
    xfer(8'h40, 6'd2);
    cmp(lowb(256'(rd_data), 2), 256'(adc_result));
    xfer(8'h41, 6'd2);
    cmp(lowb(256'(rd_data), 2), 256'(adc_result[1]));
    fill();
    exp_adc = merge(exp_adc, wr_data, 0, 2);
    xfer(8'h44, 6'd3);
    cmp(256'(adc_setup), exp_adc);
    xfer(8'h46, 6'd3);
    cmp(lowb(256'(rd_data), 3), exp_adc);
    for (i = 0; i < 3; i++) begin
      a = starts[i];
      fill();
      exp_radio = merge(exp_radio, wr_data, a, 10 - a);
      xfer({4'h0, starts[i]}, 6'(11 - a));
      cmp(256'(radio_setup), exp_radio);
      xfer({4'h1, starts[i]}, 6'(10 - a));
      cmp(lowb(256'(rd_data), 10 - a), lowb(exp_radio >> (8 * a), 10 - a));
    end
    for (i = 0; i < 4; i++) begin
      op = {4'h8, 2'(i), 2'($urandom)};
      fill();
      exp_radio[7:0] = wr_data[0];
      exp_radio[11:8] = op[3:0];
      xfer(op, 6'd1);
      cmp(256'(radio_setup), exp_radio);
    end
    xfer(8'h8f, 6'd0);
    cmp(256'(radio_setup), exp_radio);
    for (i = 0; i < 4; i++) begin
      sel = 4'($urandom);
      adc_busy = i[0];
      n0 = n_start;
      xfer({4'hc, sel}, 6'd0);
      cmp(256'(n_start - n0), 256'h1);
      cmp(256'(sel_seen), 256'(sel));
      cmp(256'(abort_seen), 256'(i[0]));
    end
    cmp(256'(early), 256'h0);
    n0 = n_start;
    fill();
    xfer(8'h45, 6'd3);
    xfer(8'hf0, 6'd3);
    cmp(256'({tx_address, adc_setup, radio_setup}),
      256'({exp_addr[31:0], exp_adc[15:0], exp_radio[79:0]}));
    cmp(256'(tx_payload), exp_pay);
    cmp(256'(n_start - n0), 256'h0);
    final_report;
  end
endmodule
